// ==== i2cst_top.v ====
// SCL period generator, bus condition detector and interrupt status with an APB slave port.
// Assumes SCL and SDA are open-drain wires resolved outside; inputs are asynchronous.
`timescale 1ns/100ps
`include "i2cst_defs.vh"
module i2cst_top (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_b_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    // I2C pins
    input  wire        scl_in,
    output wire        scl_out,
    output wire        scl_oe_out,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe_out,
    // Interrupt
    output wire        irq_out
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_ACK  = 4'b0100;
    localparam ST_SKIP = 4'b1000;

    reg  [15:0] std_scl_high_count_q;
    reg  [15:0] std_scl_low_count_q;
    reg  [15:0] fast_scl_high_count_q;
    reg  [15:0] fast_scl_low_count_q;
    reg  [15:0] high_scl_high_count_q;
    reg  [15:0] high_scl_low_count_q;
    reg  [`I2CST_CTRL_W-1:0] ctrl_q;
    reg  [`I2CST_STAT_W-1:0] mask_q;
    reg  [`I2CST_STAT_W-1:0] raw_q;
    reg  [`I2CST_STAT_W-1:0] raw_d;
    reg  [31:0] prdata_q;
    reg         pready_q;
    reg         pslverr_q;
    reg         irq_q;
    reg         scl_oe_q;
    reg         sda_oe_q;
    reg  [15:0] cnt_q;
    reg  [3:0]  state_q;
    reg  [3:0]  bitcnt_q;
    reg  [7:0]  shift_q;
    reg         scl_prev_q;
    reg         sda_prev_q;
    reg  [31:0] rdata;
    reg         hit;
    reg  [15:0] hcnt_sel;
    reg  [15:0] lcnt_sel;

    wire [1:0]  pin_sync;
    wire        scl_s;
    wire        sda_s;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_det;
    wire        stop_det;
    wire        gcall_set;
    wire        acc;
    wire        wr_en;
    wire [1:0]  speed;
    wire        run;
    wire [`I2CST_STAT_W-1:0] w1c;

    // Pin synchronisers
    i2cst_sync #(
        .W (2)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in ({sda_in, scl_in}),
        .sync_out (pin_sync)
    );
    assign scl_s = pin_sync[0];
    assign sda_s = pin_sync[1];

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Bus edges and conditions
    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // APB decode
    assign acc   = psel_in & penable_in;
    assign wr_en = acc & pready_q & pwrite_in & hit;
    assign w1c   = (wr_en && paddr_in == `I2CST_OFS_RAW) ?
                   pwdata_in[`I2CST_STAT_W-1:0] : {`I2CST_STAT_W{1'b0}};

    always @* begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr_in)
            `I2CST_OFS_STD_HCNT:  rdata = {16'h0000, std_scl_high_count_q};
            `I2CST_OFS_STD_LCNT:  rdata = {16'h0000, std_scl_low_count_q};
            `I2CST_OFS_FAST_HCNT: rdata = {16'h0000, fast_scl_high_count_q};
            `I2CST_OFS_FAST_LCNT: rdata = {16'h0000, fast_scl_low_count_q};
            `I2CST_OFS_HIGH_HCNT: rdata = {16'h0000, high_scl_high_count_q};
            `I2CST_OFS_HIGH_LCNT: rdata = {16'h0000, high_scl_low_count_q};
            `I2CST_OFS_CAUSE:     rdata = {20'h00000, raw_q & mask_q};
            `I2CST_OFS_CTRL:      rdata = {28'h0000000, ctrl_q};
            `I2CST_OFS_MASK:      rdata = {20'h00000, mask_q};
            `I2CST_OFS_RAW:       rdata = {20'h00000, raw_q};
            default:              hit   = 1'b0;
        endcase
    end

    // APB answer, one wait state
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            if (acc && !pready_q) begin
                pready_q  <= 1'b1;
                pslverr_q <= ~hit;
                prdata_q  <= pwrite_in ? 32'h0000_0000 : rdata;
            end else begin
                pready_q  <= 1'b0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            std_scl_high_count_q  <= `I2CST_RST_CNT; // RULE_10
            std_scl_low_count_q   <= `I2CST_RST_CNT;
            fast_scl_high_count_q <= `I2CST_RST_CNT;
            fast_scl_low_count_q  <= `I2CST_RST_CNT;
            high_scl_high_count_q <= `I2CST_RST_CNT;
            high_scl_low_count_q  <= `I2CST_RST_CNT;
            ctrl_q                <= `I2CST_RST_CTRL;
            mask_q                <= `I2CST_RST_STAT;
        end else if (wr_en) begin
            case (paddr_in)
                `I2CST_OFS_STD_HCNT:  std_scl_high_count_q  <= pwdata_in[15:0]; // RULE_02
                `I2CST_OFS_STD_LCNT:  std_scl_low_count_q   <= pwdata_in[15:0]; // RULE_03
                `I2CST_OFS_FAST_HCNT: fast_scl_high_count_q <= pwdata_in[15:0]; // RULE_04
                `I2CST_OFS_FAST_LCNT: fast_scl_low_count_q  <= pwdata_in[15:0]; // RULE_05
                `I2CST_OFS_HIGH_HCNT: high_scl_high_count_q <= pwdata_in[15:0]; // RULE_06
                `I2CST_OFS_HIGH_LCNT: high_scl_low_count_q  <= pwdata_in[15:0]; // RULE_06
                `I2CST_OFS_CTRL:      ctrl_q <= pwdata_in[`I2CST_CTRL_W-1:0];
                `I2CST_OFS_MASK:      mask_q <= pwdata_in[`I2CST_STAT_W-1:0];
                default:              ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Count selection by speed
    assign speed = ctrl_q[`I2CST_CTRL_SPD_HI:`I2CST_CTRL_SPD_LO];
    assign run   = ctrl_q[`I2CST_CTRL_EN] && speed != 2'h0; // RULE_01

    always @* begin
        case (speed)
            `I2CST_SPD_FAST: begin
                hcnt_sel = fast_scl_high_count_q; // RULE_04
                lcnt_sel = fast_scl_low_count_q; // RULE_05
            end
            `I2CST_SPD_HIGH: begin
                hcnt_sel = high_scl_high_count_q; // RULE_06
                lcnt_sel = high_scl_low_count_q; // RULE_06
            end
            default: begin
                hcnt_sel = std_scl_high_count_q; // RULE_02
                lcnt_sel = std_scl_low_count_q; // RULE_03
            end
        endcase
    end

    // SCL period generator; a released SCL held low by another party stretches
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scl_oe_q <= 1'b0;
            cnt_q    <= 16'h0000;
        end else if (!run) begin
            scl_oe_q <= 1'b0;
            cnt_q    <= 16'h0000;
        end else if (scl_oe_q) begin
            if (cnt_q <= 16'h0001) begin
                scl_oe_q <= 1'b0; // RULE_10
                cnt_q    <= hcnt_sel;
            end else begin
                cnt_q <= cnt_q - 16'h0001; // RULE_03
            end
        end else if (scl_s) begin
            if (cnt_q <= 16'h0001) begin
                scl_oe_q <= 1'b1; // RULE_10
                cnt_q    <= lcnt_sel;
            end else begin
                cnt_q <= cnt_q - 16'h0001; // RULE_02
            end
        end
    end

    // Address receiver for general call
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q  <= ST_IDLE;
            bitcnt_q <= 4'h0;
            shift_q  <= 8'h00;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            state_q  <= ST_ADDR;
            bitcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (scl_rise && bitcnt_q != `I2CST_BITS_PER_BYTE) begin
                        shift_q  <= {shift_q[6:0], sda_s};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end else if (scl_fall && bitcnt_q == `I2CST_BITS_PER_BYTE) begin
                        if (shift_q == `I2CST_GCALL_ADDR && ctrl_q[`I2CST_CTRL_GC_ACK]) begin
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_ACK;
                        end else begin
                            state_q <= ST_SKIP;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_SKIP;
                    end
                end
                ST_IDLE: state_q <= ST_IDLE;
                ST_SKIP: state_q <= ST_SKIP;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign gcall_set = (state_q == ST_ACK) && scl_rise && sda_oe_q;

    // Sticky status: set wins over write-one clear
    always @* begin
        raw_d = raw_q & ~w1c;
        if (gcall_set) begin
            raw_d[`I2CST_BIT_GCALL] = 1'b1; // RULE_07
        end
        if (start_det) begin
            raw_d[`I2CST_BIT_START] = 1'b1; // RULE_08
        end
        if (stop_det) begin
            raw_d[`I2CST_BIT_STOP] = 1'b1; // RULE_09
        end
    end

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            raw_q <= `I2CST_RST_STAT; // RULE_10
            irq_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
            irq_q <= |(raw_d & mask_q);
        end
    end

    // Outputs
    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;
    assign scl_out     = 1'b0;
    assign scl_oe_out  = scl_oe_q;
    assign sda_out     = 1'b0;
    assign sda_oe_out  = sda_oe_q;
    assign irq_out     = irq_q;
endmodule // i2cst_top

// ==== i2cst_defs.vh ====
// Register map, field positions and reset values of the SCL timing and status block.
// Assumes a 32-bit APB slave port and a 200 MHz module clock.
//
// Contract
// (RULE_01) Software programs the SCL high and low counts for the speed in use before any transfer.
// (RULE_02) Standard speed holds SCL high for the 16-bit count at offset 0x14.
// (RULE_03) Standard speed holds SCL low for the 16-bit count at offset 0x18.
// (RULE_04) Fast speed takes its SCL high length from the 16-bit count at offset 0x1c.
// (RULE_05) Fast speed takes its SCL low length from the 16-bit count at offset 0x20.
// (RULE_06) High speed takes SCL high from offset 0x24 and SCL low from offset 0x28.
// (RULE_07) Status bit 11 is set only when the general call address is received and acknowledged.
// (RULE_08) Status bit 10 is set when a START or RESTART appears on the bus.
// (RULE_09) A status bit is set whenever a STOP appears on the bus.
// (RULE_10) Period counters count module clocks and reload on each SCL phase change; counts and flags reset to zero.
`ifndef I2CST_DEFS_VH
`define I2CST_DEFS_VH

// Byte offsets
`define I2CST_OFS_STD_HCNT   8'h14
`define I2CST_OFS_STD_LCNT   8'h18
`define I2CST_OFS_FAST_HCNT  8'h1c
`define I2CST_OFS_FAST_LCNT  8'h20
`define I2CST_OFS_HIGH_HCNT  8'h24
`define I2CST_OFS_HIGH_LCNT  8'h28
`define I2CST_OFS_CAUSE      8'h2c
`define I2CST_OFS_CTRL       8'h30
`define I2CST_OFS_MASK       8'h34
`define I2CST_OFS_RAW        8'h38

// Control fields
`define I2CST_CTRL_EN        0
`define I2CST_CTRL_SPD_LO    1
`define I2CST_CTRL_SPD_HI    2
`define I2CST_CTRL_GC_ACK    3
`define I2CST_CTRL_W         4

// Speed codes
`define I2CST_SPD_STD        2'h1
`define I2CST_SPD_FAST       2'h2
`define I2CST_SPD_HIGH       2'h3

// Status fields
`define I2CST_BIT_STOP       9
`define I2CST_BIT_START      10
`define I2CST_BIT_GCALL      11
`define I2CST_STAT_W         12

// Reset values
`define I2CST_RST_CNT        16'h0000
`define I2CST_RST_CTRL       4'h0
`define I2CST_RST_STAT       12'h000

// Bus constants
`define I2CST_GCALL_ADDR     8'h00
`define I2CST_BITS_PER_BYTE  4'h8

`endif

// ==== i2cst_sync.v ====
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/100ps
module i2cst_sync #(
    parameter W = 2
) (
    // Clock and reset
    input  wire         clk_in,
    input  wire         rst_b_in,
    // Data
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate
endmodule // i2cst_sync

// ==== i2cst_asserts.sv ====
// Port checks for the SCL timing and status block.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/100ps
module i2cst_asserts (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        scl_oe_out,
    input wire logic        sda_oe_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    logic [15:0] cnt_q [6];
    logic [3:0]  ctrl_q;
    logic [16:0] low_q;
    logic [16:0] high_q;
    logic        run_q;
    wire  [7:0]  ofs  = paddr_in - 8'h14;
    wire  [2:0]  ix   = {ctrl_q[2:1] - 2'h1, 1'b0};
    wire  [15:0] hsel = cnt_q[ix];
    wire  [15:0] lsel = cnt_q[ix + 3'h1];
    wire  [16:0] hexp = (hsel < 16'h0002) ? 17'h00001 : {1'b0, hsel};
    wire  [16:0] lexp = (lsel < 16'h0002) ? 17'h00001 : {1'b0, lsel};
    wire         wr   = psel_in & penable_in & pready_out & pwrite_in;
    wire         cnt  = paddr_in >= 8'h14 && paddr_in <= 8'h28;
    // Shadow of counts and control, plus SCL phase lengths
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q  <= '{default: 16'h0000};
            ctrl_q <= 4'h0;
            low_q  <= 17'h00000;
            high_q <= 17'h00000;
            run_q  <= 1'b0;
        end else begin
            low_q  <= scl_oe_out ? low_q + 17'h00001 : 17'h00000;
            high_q <= scl_oe_out ? 17'h00000 : high_q + 17'h00001;
            run_q  <= run_q | scl_oe_out;
            if (wr && cnt) begin
                cnt_q[ofs[4:2]] <= pwdata_in[15:0];
            end
            if (wr && paddr_in == 8'h30) begin
                ctrl_q <= pwdata_in[3:0];
            end
        end
    end
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_access;
        psel_in && penable_in && !pready_out;
    endsequence
    a_ready_wait: assert property (s_setup ##1 s_access |=> pready_out)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_slverr_gate: assert property (pslverr_out |-> pready_out && psel_in)
        else $error("slave error outside an answer");
    a_reset_quiet: assert property (!$past(rst_b_in) |-> !(irq_out | scl_oe_out | sda_oe_out))
        else $error("output active after reset");
    a_scl_low_len: assert property ($fell(scl_oe_out) |-> low_q == lexp)
        else $error("scl low length wrong");
    a_scl_high_len: assert property ($rose(scl_oe_out) && run_q |-> high_q >= hexp && high_q <= hexp + 17'h00004)
        else $error("scl high length wrong");
    a_gcall_gate: assert property (sda_oe_out |-> ctrl_q[3])
        else $error("acknowledge while disabled");
    a_ack_hold: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
        else $error("acknowledge too short");
    a_cnt_upper: assert property (pready_out && !pwrite_in && cnt |-> prdata_out[31:16] == 16'h0000)
        else $error("count upper bits not zero");
endmodule // i2cst_asserts

bind i2cst_top i2cst_asserts i_chk (
    .clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .scl_oe_out, .sda_oe_out, .irq_out
);

// ==== i2cst_bus_master.sv ====
// Behavioural bus master driving SCL and SDA through pull-down enables.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/100ps
module i2cst_bus_master (
    // Bus wire
    input  wire logic sda_in,
    // Pull-down enables
    output logic      scl_low_out = 1'b0,
    output logic      sda_low_out = 1'b0
);
    localparam realtime QTR = 31.25;
    task automatic start_cond();
        sda_low_out = 1'b0;
        #QTR scl_low_out = 1'b0;
        #QTR sda_low_out = 1'b1;
        #QTR scl_low_out = 1'b1;
        #QTR;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low_out = ~b[i];
            #QTR scl_low_out = 1'b0;
            #(2 * QTR) scl_low_out = 1'b1;
            #QTR;
        end
        sda_low_out = 1'b0;
        #QTR scl_low_out = 1'b0;
        #QTR ack = ~sda_in;
        #QTR scl_low_out = 1'b1;
        #QTR;
    endtask
    task automatic stop_cond();
        sda_low_out = 1'b1;
        #QTR scl_low_out = 1'b0;
        #QTR sda_low_out = 1'b0;
        #QTR;
    endtask
endmodule // i2cst_bus_master

// ==== i2c_scl_timing_and_intr_status_tb_top.sv ====
// Self-checking bench for the SCL timing and status block.
// Assumes the bus master model and bound checker beside the block.
`timescale 1ns/100ps
module i2c_scl_timing_and_intr_status_tb_top;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000;
    wire  [31:0] prdata_out;
    wire         pready_out, pslverr_out, scl_oe_out, sda_oe_out, irq_out;
    wire         scl_out, sda_out;
    wire         m_scl, m_sda;
    wire         scl_in = ~(scl_oe_out | m_scl);
    wire         sda_in = ~(sda_oe_out | m_sda);
    int          mismatches = 0;
    int          total_checks = 0;
    int          n;
    logic [31:0] rd;
    logic        er, a1, a2;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} i2cst_row_t;
    i2cst_row_t  rows [9] = '{
        '{8'h14, 32'hffff_0009, 32'h0000_0009, 1'b0},
        '{8'h18, 32'h0000_0007, 32'h0000_0007, 1'b0},
        '{8'h1c, 32'h1234_0004, 32'h0000_0004, 1'b0},
        '{8'h20, 32'h0000_0001, 32'h0000_0001, 1'b0},
        '{8'h24, 32'h8000_0002, 32'h0000_0002, 1'b0},
        '{8'h28, 32'habcd_0000, 32'h0000_0000, 1'b0},
        '{8'h2c, 32'hffff_ffff, 32'h0000_0000, 1'b0},
        '{8'h3c, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{8'h00, 32'h0000_0055, 32'h0000_0000, 1'b1}};
    logic [31:0] lo [4] = '{32'h0000_0000, 32'h0000_0007, 32'h0000_0001, 32'h0000_0001};
    i2cst_top i_dut (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .scl_in, .scl_out, .scl_oe_out,
        .sda_in, .sda_out, .sda_oe_out, .irq_out);
    i2cst_bus_master i_master (.sda_in, .scl_low_out(m_scl), .sda_low_out(m_sda));
    always #2.5 clk_in = ~clk_in;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) begin
            @(posedge clk_in);
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, x, rd);
    endtask
    task automatic do_reset();
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        mismatches++;
        final_report();
    end
    initial begin
        do_reset();
        for (int a = 20; a <= 56; a += 4) rchk("reset_value", 8'(a), 32'h0000_0000);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            rchk("read_data", rows[i].a, rows[i].x);
            chk("slave_error", {31'h0, rows[i].e}, {31'h0, er});
        end
        $display("test registers done");
        for (int s = 1; s <= 3; s++) begin
            apb(1'b1, 8'h30, 32'(2 * s + 1));
            n = 0;
            while (scl_oe_out !== 1'b1 && n < 500) begin
                @(posedge clk_in);
                n++;
            end
            n = 0;
            while (scl_oe_out === 1'b1 && n < 500) begin
                @(posedge clk_in);
                n++;
            end
            chk("scl_low_cycles", lo[s], 32'(n));
            repeat (80) @(posedge clk_in);
            do_reset();
            chk("scl_released", 32'h0000_0000, {31'h0, scl_oe_out});
            chk("pin_drive_levels", 32'h0000_0000, {30'h0, scl_out, sda_out});
            for (int i = 0; i < 6; i++) apb(1'b1, rows[i].a, rows[i].d);
        end
        $display("test scl done");
        apb(1'b1, 8'h34, 32'h0000_0e00);
        apb(1'b1, 8'h30, 32'h0000_0008);
        i_master.start_cond();
        i_master.send_byte(8'ha2, a1);
        i_master.start_cond();
        i_master.send_byte(8'h00, a2);
        i_master.stop_cond();
        @(posedge clk_in);
        chk("ack_other", 32'h0000_0000, {31'h0, a1});
        chk("ack_general", 32'h0000_0001, {31'h0, a2});
        rchk("raw_flags", 8'h38, 32'h0000_0e00);
        rchk("cause_flags", 8'h2c, 32'h0000_0e00);
        chk("irq_set", 32'h0000_0001, {31'h0, irq_out});
        apb(1'b1, 8'h38, 32'h0000_0400);
        rchk("partial_clear", 8'h38, 32'h0000_0a00);
        apb(1'b1, 8'h38, 32'h0000_0a00);
        apb(1'b1, 8'h30, 32'h0000_0000);
        chk("irq_cleared", 32'h0000_0000, {31'h0, irq_out});
        apb(1'b1, 8'h34, 32'h0000_0400);
        i_master.start_cond();
        i_master.send_byte(8'h00, a1);
        i_master.stop_cond();
        @(posedge clk_in);
        chk("ack_disabled", 32'h0000_0000, {31'h0, a1});
        rchk("raw_no_call", 8'h38, 32'h0000_0600);
        rchk("cause_masked", 8'h2c, 32'h0000_0400);
        apb(1'b1, 8'h34, 32'h0000_0000);
        repeat (2) @(posedge clk_in);
        chk("irq_masked", 32'h0000_0000, {31'h0, irq_out});
        $display("test events done");
        final_report();
    end
endmodule // i2c_scl_timing_and_intr_status_tb_top
